// file: dcff_pkg.sv
// constants and types for the dual-clock fifo flag and expansion block
// assumes a single core clock; write and read ports are enables on that clock
package dcff_pkg;
  localparam int unsigned DCFF_DATA_W = 18;
  localparam int unsigned DCFF_DEPTH = 256;
  localparam int unsigned DCFF_PTR_W = 8;
  localparam int unsigned DCFF_CNT_W = 9;
  localparam logic [8:0] DCFF_FULL_CNT = 9'h100;
  localparam logic [8:0] DCFF_HALF_CNT = 9'h080;
  localparam logic [7:0] DCFF_LAST_LOC = 8'hff;
  // default almost offset follows depth: 31 for 256, 63 for 512, 127 above
  localparam logic [8:0] DCFF_OFFSET_DEFAULT =
    (DCFF_DEPTH == 256) ? 9'h01f : (DCFF_DEPTH == 512) ? 9'h03f : 9'h07f;
  localparam int unsigned DCFF_FALL_THROUGH_NS = 150;
  localparam int unsigned DCFF_CLK_NS = 50;
  localparam logic [1:0] DCFF_FT_CYCLES =
    2'((DCFF_FALL_THROUGH_NS + DCFF_CLK_NS - 1) / DCFF_CLK_NS);
  localparam logic [DCFF_DATA_W-1:0] DCFF_DATA_RESET = 18'h00000;

  typedef struct packed {
    logic fall_through_mode;
    logic sync_almost;
  } dcff_mode_type;

  // strap table indexed by {first load, write exp in, read exp in}
  localparam dcff_mode_type DCFF_MODE_TABLE [8] = '{
    '{1'b1, 1'b0}, '{1'b1, 1'b1}, '{1'b0, 1'b0}, '{1'b0, 1'b1},
    '{1'b1, 1'b0}, '{1'b1, 1'b1}, '{1'b0, 1'b0}, '{1'b0, 1'b1}
  };

  typedef struct packed {
    logic full_flag_n;
    logic empty_flag_n;
    logic almost_empty_n;
    logic almost_full_n;
    logic half_full_n;
  } dcff_flags_type;

  typedef enum logic [1:0] {
    DCFF_OUT_IDLE = 2'b00,
    DCFF_OUT_FALL = 2'b01,
    DCFF_OUT_VALID = 2'b10
  } dcff_out_state_type;
endpackage

// file: dcff_fifo.sv
// 18-bit fifo core with fixed and almost flags, timing mode straps and
// daisy-chain depth expansion tokens
// assumes all inputs are synchronous to core_clk_i
`timescale 1ns/100ps
// Function
// R1 - straps fl, wxi, rxi choose timing mode and almost flag sync
// R2 - chain: first device ties first load low, later devices high
// R3 - chain: write expansion input comes from previous write expansion out
// R4 - chain: read expansion input comes from previous read expansion out
// R5 - standard mode: full output low when no free location
// R6 - fall-through mode: same output shows space for another write
// R7 - standard mode: empty output low when nothing stored
// R8 - fall-through mode: empty output shows valid word on outputs
// R9 - almost-empty low within offset of empty, default by depth
// R10 - almost-full low within offset of full, default by depth
// R11 - single use: half-full output low above half capacity
// R12 - depth mode: pulse write expansion out on last location written
// R13 - depth mode: pulse read expansion out on last location read
// R14 - read data output is eighteen bits wide
// R15 - reset: pointers home, full and almost-full high, others low; half-full and both expansion outputs reset high
// R16 - write on enable low, ignored while full
// R17 - read on enable low, ignored while empty
// R18 - fall-through: first word appears after three clocks unrequested
// R19 - strap encoding is a parameter table of four mode combinations
// R20 - default offset is a parameter tied to depth
module dcff_fifo
  import dcff_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic depth_expansion_i,
  input wire logic first_load_strap_n_i,
  input wire logic write_expansion_in_n_i,
  input wire logic read_expansion_in_n_i,
  input wire logic write_enable_n_i,
  input wire logic read_enable_n_i,
  input wire logic [DCFF_DATA_W-1:0] write_data_in_i,
  output logic [DCFF_DATA_W-1:0] read_data_out_o,
  output logic full_flag_n_o,
  output logic empty_flag_n_o,
  output logic almost_empty_n_o,
  output logic almost_full_n_o,
  output logic write_expansion_out_n_o,
  output logic read_expansion_out_n_o,
  output logic fall_through_mode_o
);

  logic [DCFF_DATA_W-1:0] mem_r [DCFF_DEPTH];
  logic [DCFF_PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
  logic [DCFF_PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
  logic [DCFF_CNT_W-1:0] count_r, count_nxt;
  logic [DCFF_DATA_W-1:0] dout_r, dout_nxt;
  dcff_out_state_type out_state_r, out_state_nxt;
  logic [1:0] fall_cnt_r, fall_cnt_nxt;
  dcff_mode_type mode_r, mode_nxt;
  logic captured_r, captured_nxt;
  logic depth_mode_r, depth_mode_nxt;
  logic wr_token_r, wr_token_nxt;
  logic rd_token_r, rd_token_nxt;
  dcff_flags_type flags_r, flags_nxt;
  logic wxo_n_r, wxo_n_nxt;
  logic rxo_n_r, rxo_n_nxt;
  logic do_write, do_pop;
  logic ae_now, af_now;

  // straps are read once, on the first edge after reset release
  always_comb begin
    captured_nxt = 1'b1;
    mode_nxt = mode_r;
    depth_mode_nxt = depth_mode_r;
    if (!captured_r) begin
      depth_mode_nxt = depth_expansion_i;
      if (depth_expansion_i) begin
        mode_nxt = '{1'b0, 1'b0};
      end else begin
        mode_nxt = DCFF_MODE_TABLE[{first_load_strap_n_i, write_expansion_in_n_i,
                                    read_expansion_in_n_i}]; // R1 R19
      end
    end
  end

  // write side, gated by full and, in a chain, by the write token
  always_comb begin
    do_write = captured_r && !write_enable_n_i && (count_r != DCFF_FULL_CNT) // R16
               && (!depth_mode_r || wr_token_r);
    wr_ptr_nxt = do_write ? wr_ptr_r + 8'h01 : wr_ptr_r;
  end

  // output stage: standard reads on request, fall-through self-loads
  always_comb begin
    do_pop = 1'b0;
    out_state_nxt = out_state_r;
    fall_cnt_nxt = fall_cnt_r;
    dout_nxt = dout_r;
    if (!captured_r) begin
      out_state_nxt = DCFF_OUT_IDLE;
    end else if (!mode_r.fall_through_mode) begin
      if (!read_enable_n_i && count_r != '0 && (!depth_mode_r || rd_token_r)) begin // R17
        do_pop = 1'b1;
      end
    end else begin
      unique case (out_state_r)
        DCFF_OUT_IDLE: begin
          if (count_r != '0) begin
            out_state_nxt = DCFF_OUT_FALL;
            fall_cnt_nxt = DCFF_FT_CYCLES - 2'h1;
          end
        end
        DCFF_OUT_FALL: begin
          if (fall_cnt_r == 2'h1) begin
            do_pop = 1'b1; // R18
            out_state_nxt = DCFF_OUT_VALID;
          end else begin
            fall_cnt_nxt = fall_cnt_r - 2'h1;
          end
        end
        DCFF_OUT_VALID: begin
          if (!read_enable_n_i) begin
            if (count_r != '0) begin
              do_pop = 1'b1;
            end else begin
              out_state_nxt = DCFF_OUT_IDLE;
            end
          end
        end
        default: begin
          out_state_nxt = DCFF_OUT_IDLE;
        end
      endcase
    end
    if (do_pop) begin
      dout_nxt = mem_r[rd_ptr_r]; // R14
    end
    rd_ptr_nxt = do_pop ? rd_ptr_r + 8'h01 : rd_ptr_r;
  end

  always_comb begin
    count_nxt = count_r;
    if (do_write && !do_pop) begin
      count_nxt = count_r + 9'h001;
    end else if (!do_write && do_pop) begin
      count_nxt = count_r - 9'h001;
    end
  end

  // chain tokens; an incoming pulse wins over a clear in the same cycle
  always_comb begin
    wr_token_nxt = wr_token_r;
    rd_token_nxt = rd_token_r;
    wxo_n_nxt = 1'b1;
    rxo_n_nxt = 1'b1;
    if (!captured_r) begin
      wr_token_nxt = !first_load_strap_n_i; // R2
      rd_token_nxt = !first_load_strap_n_i;
    end else if (depth_mode_r) begin
      if (do_write && wr_ptr_r == DCFF_LAST_LOC) begin
        wr_token_nxt = 1'b0;
        wxo_n_nxt = 1'b0; // R12
      end
      if (do_pop && rd_ptr_r == DCFF_LAST_LOC) begin
        rd_token_nxt = 1'b0;
        rxo_n_nxt = 1'b0; // R13
      end
      if (!write_expansion_in_n_i) begin
        wr_token_nxt = 1'b1; // R3
      end
      if (!read_expansion_in_n_i) begin
        rd_token_nxt = 1'b1; // R4
      end
    end
  end

  // flags; synchronous almost flags lag one cycle behind the count
  always_comb begin
    ae_now = !(count_nxt <= DCFF_OFFSET_DEFAULT); // R9 R20
    af_now = !(count_nxt >= DCFF_FULL_CNT - DCFF_OFFSET_DEFAULT); // R10
    flags_nxt.full_flag_n = (count_nxt != DCFF_FULL_CNT); // R5 R6
    if (mode_r.fall_through_mode) begin
      flags_nxt.empty_flag_n = (out_state_nxt == DCFF_OUT_VALID); // R8
    end else begin
      flags_nxt.empty_flag_n = (count_nxt != '0); // R7
    end
    flags_nxt.half_full_n = !(count_nxt > DCFF_HALF_CNT); // R11
    if (mode_r.sync_almost) begin
      flags_nxt.almost_empty_n = !(count_r <= DCFF_OFFSET_DEFAULT);
      flags_nxt.almost_full_n = !(count_r >= DCFF_FULL_CNT - DCFF_OFFSET_DEFAULT);
    end else begin
      flags_nxt.almost_empty_n = ae_now;
      flags_nxt.almost_full_n = af_now;
    end
    if (!captured_r) begin
      flags_nxt = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_r <= '0; // R15
      rd_ptr_r <= '0;
      count_r <= '0;
      dout_r <= DCFF_DATA_RESET;
      out_state_r <= DCFF_OUT_IDLE;
      fall_cnt_r <= 2'h0;
      mode_r <= '{1'b0, 1'b0};
      captured_r <= 1'b0;
      depth_mode_r <= 1'b0;
      wr_token_r <= 1'b0;
      rd_token_r <= 1'b0;
      flags_r <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      wxo_n_r <= 1'b1;
      rxo_n_r <= 1'b1;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
      dout_r <= dout_nxt;
      out_state_r <= out_state_nxt;
      fall_cnt_r <= fall_cnt_nxt;
      mode_r <= mode_nxt;
      captured_r <= captured_nxt;
      depth_mode_r <= depth_mode_nxt;
      wr_token_r <= wr_token_nxt;
      rd_token_r <= rd_token_nxt;
      flags_r <= flags_nxt;
      wxo_n_r <= wxo_n_nxt;
      rxo_n_r <= rxo_n_nxt;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge core_clk_i) begin
    if (do_write) begin
      mem_r[wr_ptr_r] <= write_data_in_i; // R16
    end
  end

  assign read_data_out_o = dout_r;
  assign full_flag_n_o = flags_r.full_flag_n;
  assign empty_flag_n_o = flags_r.empty_flag_n;
  assign almost_empty_n_o = flags_r.almost_empty_n;
  assign almost_full_n_o = flags_r.almost_full_n;
  // shared pin: half-full alone, write pulse in a chain
  assign write_expansion_out_n_o = depth_mode_r ? wxo_n_r : flags_r.half_full_n;
  assign read_expansion_out_n_o = rxo_n_r;
  assign fall_through_mode_o = mode_r.fall_through_mode;

endmodule

// file: dcff_fifo_checker.sv
// port-level checks for the fifo flag and expansion block
// assumes one core clock and an active-low asynchronous reset
`timescale 1ns/100ps
module dcff_fifo_checker
  import dcff_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic depth_expansion_i,
  input wire logic write_enable_n_i,
  input wire logic read_enable_n_i,
  input wire logic [DCFF_DATA_W-1:0] read_data_out_o,
  input wire logic full_flag_n_o,
  input wire logic empty_flag_n_o,
  input wire logic almost_empty_n_o,
  input wire logic almost_full_n_o,
  input wire logic write_expansion_out_n_o,
  input wire logic read_expansion_out_n_o,
  input wire logic fall_through_mode_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_RESET_VALUES: assert property (
    $rose(reset_n_i) |-> full_flag_n_o && !empty_flag_n_o && !almost_empty_n_o
      && almost_full_n_o && read_expansion_out_n_o) else $error("reset values wrong");
  AST_FULL_HOLDS: assert property (
    !fall_through_mode_o && !full_flag_n_o && !write_enable_n_i && read_enable_n_i
      |=> !full_flag_n_o) else $error("write into full fifo changed full");
  AST_EMPTY_HOLDS: assert property (
    !fall_through_mode_o && !empty_flag_n_o && !read_enable_n_i && write_enable_n_i
      |=> !empty_flag_n_o && $stable(read_data_out_o)) else $error("read from empty");
  AST_FIRST_WRITE: assert property (
    !fall_through_mode_o && !depth_expansion_i && !empty_flag_n_o && !write_enable_n_i
      && read_enable_n_i && !$rose(reset_n_i) |=> empty_flag_n_o)
    else $error("write to empty did not clear empty");
  AST_FULL_ALMOST: assert property (
    !full_flag_n_o |-> !almost_full_n_o) else $error("full without almost full");
  AST_EMPTY_ALMOST: assert property (
    !fall_through_mode_o && !empty_flag_n_o |-> !almost_empty_n_o)
    else $error("empty without almost empty");
  AST_HALF_FULL: assert property (
    !depth_expansion_i && !write_expansion_out_n_o |-> almost_empty_n_o && empty_flag_n_o)
    else $error("half full with low fill");
  AST_WXO_PULSE: assert property (
    depth_expansion_i && $fell(write_expansion_out_n_o) |=> write_expansion_out_n_o)
    else $error("write token pulse too long");
  AST_RXO_PULSE: assert property (
    $fell(read_expansion_out_n_o) |-> depth_expansion_i ##1 read_expansion_out_n_o)
    else $error("read token pulse wrong");
endmodule
bind dcff_fifo dcff_fifo_checker chk_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .depth_expansion_i(depth_expansion_i), .write_enable_n_i(write_enable_n_i),
  .read_enable_n_i(read_enable_n_i), .read_data_out_o(read_data_out_o),
  .full_flag_n_o(full_flag_n_o), .empty_flag_n_o(empty_flag_n_o),
  .almost_empty_n_o(almost_empty_n_o), .almost_full_n_o(almost_full_n_o),
  .write_expansion_out_n_o(write_expansion_out_n_o),
  .read_expansion_out_n_o(read_expansion_out_n_o), .fall_through_mode_o(fall_through_mode_o));

// file: dcff_reader_model.sv
// reader logic on the far side of the read port, stalling at random
// assumes the read enable is sampled on the rising core clock edge
`timescale 1ns/100ps
module dcff_reader_model #(
  parameter int SEED = 7
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  output logic read_enable_n_o
);
  int seed = SEED;
  initial read_enable_n_o = 1'b1;
  // requests even while empty, so that refused reads occur too
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      read_enable_n_o <= 1'b1;
    end else begin
      read_enable_n_o <= !(enable_i && ($random(seed) % 3 != 0));
    end
  end
endmodule

// file: test_dual_clock_fifo_flags_expansion.sv
// self-checking bench for the fifo flag and expansion block
// assumes the reader model on the read port and expansion outputs looped back in depth mode
`timescale 1ns/100ps
module test_dual_clock_fifo_flags_expansion;
  import dcff_pkg::*;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, depth_i = 1'b0, fl_n = 1'b1;
  logic wxs_n = 1'b1, rxs_n = 1'b0, wen_n = 1'b1, go = 1'b0, took;
  logic full_n, empty_n, ae_n, af_n, wxo_n, rxo_n, ft, ren_n;
  logic [DCFF_DATA_W-1:0] wdata = '0, q;
  logic [DCFF_DATA_W-1:0] exp_q[$];
  int errors = 0, num_checks = 0, seed = 99615, cnt = 0, wxo_seen = 0, rxo_seen = 0;
  always #25 core_clk_i = ~core_clk_i;
  dcff_fifo uut(.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .depth_expansion_i(depth_i),
    .first_load_strap_n_i(fl_n), .write_expansion_in_n_i(depth_i ? wxo_n : wxs_n),
    .read_expansion_in_n_i(depth_i ? rxo_n : rxs_n),
    .write_enable_n_i(wen_n), .read_enable_n_i(ren_n), .write_data_in_i(wdata),
    .read_data_out_o(q), .full_flag_n_o(full_n), .empty_flag_n_o(empty_n),
    .almost_empty_n_o(ae_n), .almost_full_n_o(af_n), .write_expansion_out_n_o(wxo_n),
    .read_expansion_out_n_o(rxo_n), .fall_through_mode_o(ft));
  dcff_reader_model #(.SEED(5)) rdr(.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .enable_i(go), .read_enable_n_o(ren_n));
  function automatic logic [4:0] exp_flags(int c);
    return {c != DCFF_DEPTH, c != 0, c > int'(DCFF_OFFSET_DEFAULT),
      c < DCFF_DEPTH - int'(DCFF_OFFSET_DEFAULT), depth_i | (c <= DCFF_DEPTH / 2)};
  endfunction
  function automatic logic [4:0] got_flags();
    return {full_n, empty_n, ae_n, af_n, depth_i | wxo_n};
  endfunction
  task automatic chk(input string s, input logic [17:0] e, input logic [17:0] g);
    num_checks++;
    if (e !== g) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // straps are {depth, first load, write exp in, read exp in}
  task automatic restart(input logic [3:0] s);
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    {depth_i, fl_n, wxs_n, rxs_n} <= s;
    repeat (8) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    {cnt, wxo_seen, rxo_seen} = '0;
    exp_q.delete();
    chk("reset_flags", exp_flags(0), got_flags());
    chk("mode", 18'(!s[3] && !s[1]), 18'(ft));
  endtask
  task automatic wr(input int n);
    logic [DCFF_DATA_W-1:0] v;
    repeat (n) begin
      v = DCFF_DATA_W'($random(seed));
      wen_n <= 1'b0;
      wdata <= v;
      @(posedge core_clk_i);
      if (cnt < DCFF_DEPTH) begin
        exp_q.push_back(v);
        cnt++;
      end
      #1;
      if (!ft) chk("flags", exp_flags(cnt), got_flags());
    end
    wen_n <= 1'b1;
  endtask
  task automatic drain();
    int k;
    go <= 1'b1;
    for (k = 0; k < 3000 && cnt > 0; k++) @(posedge core_clk_i);
    go <= 1'b0;
    if (cnt > 0) begin
      chk("drain_left", 18'h0, 18'(cnt));
      wrap_up();
    end
    repeat (3) @(posedge core_clk_i);
  endtask
  always @(posedge core_clk_i) begin
    took = !ren_n && empty_n && !ft;
    #1;
    if (took) begin
      chk("read_data", exp_q.pop_front(), q);
      cnt = cnt - 1;
      chk("flags", exp_flags(cnt), got_flags());
    end
    if (!wxo_n && depth_i) wxo_seen++;
    if (!rxo_n) rxo_seen++;
  end
  initial begin
    restart(4'h6);
    wr(DCFF_DEPTH + 1);
    drain();
    repeat (3) begin
      wr(($random(seed) & 8'hff) + 1);
      drain();
    end
    // write expansion strap low selects fall-through, read strap high gives sync almost flags
    restart(4'h1);
    wr(1);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("ft_empty", 18'h0, 18'(empty_n));
    @(posedge core_clk_i);
    #1;
    chk("ft_ready", 18'h1, 18'(empty_n));
    chk("ft_data", exp_q[0], q);
    chk("ft_space", 18'h1, 18'(full_n));
    restart(4'hb);
    wr(DCFF_DEPTH + 1);
    chk("wxo_pulses", 18'h1, 18'(wxo_seen));
    drain();
    chk("rxo_pulses", 18'h1, 18'(rxo_seen));
    wrap_up();
  end
endmodule
